// ==== design/port1_pin_function_control.sv ====
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - An 8-bit output latch sets each pin's driven level and pull-up when select A and B are both clear.
// - Reading the input register returns the sampled pin levels.
// - Pins in an inverted-read state return the complement of the pin.
// - Pin levels are readable whatever the pin's direction.
// - An 8-bit direction register selects input or output per pin when select A and B are both clear.
// - An 8-bit select register A picks each pin's function with B.
// - An 8-bit select register B, with A, latch and direction, sets output.
// - A peripheral input on a pin receives that pin's sampled data, complemented in an inverted-read state.
module port1_pin_function_control
  import port1_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  output logic [NUM_PINS-1:0] pull_up_o,
  output logic [NUM_PINS-1:0] slow_slew_o,
  input wire logic serial_data_out_i,
  output logic serial_data_in_o
);
  typedef struct packed {
    logic [DATA_W-1:0] latch;
    logic [DATA_W-1:0] dir;
    logic [DATA_W-1:0] sel_a;
    logic [DATA_W-1:0] sel_b;
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [DATA_W-1:0] rdata;
  } state_s;

  state_s state_r;
  state_s state_nxt;
  logic [NUM_PINS-1:0] drive;
  logic [NUM_PINS-1:0] drive_en;
  logic [NUM_PINS-1:0] pull;
  logic [NUM_PINS-1:0] slow;
  logic [NUM_PINS-1:0] inv;
  logic [DATA_W-1:0] pin_read;
  logic hit_latch;
  logic hit_input;
  logic hit_dir;
  logic hit_sel_a;
  logic hit_sel_b;
  logic hit_any;
  logic wr_latch;
  logic wr_dir;
  logic wr_sel_a;
  logic wr_sel_b;
  logic [DATA_W-1:0] read_word;

  for (genvar i = 0; i < NUM_PINS; i++)
  begin : g_pin
    pin_function_cell pin_function_cell_inst (
      .sel_a_i(state_r.sel_a[i]),
      .sel_b_i(state_r.sel_b[i]),
      .latch_i(state_r.latch[i]),
      .dir_i(state_r.dir[i]),
      .serial_data_i(serial_data_out_i),
      .drive_o(drive[i]),
      .drive_en_o(drive_en[i]),
      .pull_up_o(pull[i]),
      .slow_slew_o(slow[i]),
      .invert_read_o(inv[i])
    );
  end

  // Address decode, one hit per register
  always_comb
  begin
    hit_latch = addr_i == ADDR_OUTPUT_LATCH;
    hit_input = addr_i == ADDR_PIN_INPUT;
    hit_dir = addr_i == ADDR_DIRECTION;
    hit_sel_a = addr_i == ADDR_FUNC_SEL_A;
    hit_sel_b = addr_i == ADDR_FUNC_SEL_B;
    hit_any = hit_latch | hit_input | hit_dir | hit_sel_a | hit_sel_b;
  end

  // Write enables; the input register has none, so writes to it are lost
  always_comb
  begin
    wr_latch = wr_i & hit_latch;
    wr_dir = wr_i & hit_dir;
    wr_sel_a = wr_i & hit_sel_a;
    wr_sel_b = wr_i & hit_sel_b;
  end

  // Word that a read returns; unmapped addresses give the idle value
  always_comb
  begin
    read_word = UNMAPPED_READ;
    if (!hit_any)
    begin
      read_word = UNMAPPED_READ;
    end
    else if (hit_latch)
    begin
      read_word = state_r.latch;
    end
    else if (hit_input)
    begin
      read_word = pin_read;
    end
    else if (hit_dir)
    begin
      read_word = state_r.dir;
    end
    else if (hit_sel_a)
    begin
      read_word = state_r.sel_a;
    end
    else if (hit_sel_b)
    begin
      read_word = state_r.sel_b;
    end
  end

  // Synchronised pin level, inverted where configured, direction-independent
  always_comb
  begin
    pin_read = '0;
    pin_read[NUM_PINS-1:0] = state_r.sync2 ^ inv;
  end

  // Next state: two-stage pin sampling, control writes, one-cycle read data
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.sync1 = pin_i;
    state_nxt.sync2 = state_r.sync1;
    if (wr_latch)
    begin
      state_nxt.latch = wdata_i;
    end
    if (wr_dir)
    begin
      state_nxt.dir = wdata_i;
    end
    if (wr_sel_a)
    begin
      state_nxt.sel_a = wdata_i;
    end
    if (wr_sel_b)
    begin
      state_nxt.sel_b = wdata_i;
    end
    // Read data stands one cycle after the strobe and idles otherwise
    if (rd_i)
    begin
      state_nxt.rdata = read_word;
    end
    else
    begin
      state_nxt.rdata = UNMAPPED_READ;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_r.latch <= RESET_OUTPUT_LATCH;
      state_r.dir <= RESET_DIRECTION;
      state_r.sel_a <= RESET_FUNC_SEL_A;
      state_r.sel_b <= RESET_FUNC_SEL_B;
      state_r.sync1 <= '0;
      state_r.sync2 <= '0;
      state_r.rdata <= UNMAPPED_READ;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign rdata_o = state_r.rdata;
  assign pin_o = drive;
  assign pin_oe_o = drive_en;
  assign pull_up_o = pull;
  assign slow_slew_o = slow;
  // Serial input sees the same (possibly inverted) data as a read
  assign serial_data_in_o = pin_read[SERIAL_IN_PIN];
endmodule

// ==== pkg/port1_pkg.sv ====
package port1_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int NUM_PINS = 2;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_LATCH = 16'h7F44;
  localparam logic [ADDR_W-1:0] ADDR_PIN_INPUT = 16'h7F45;
  localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 16'h7F46;
  localparam logic [ADDR_W-1:0] ADDR_FUNC_SEL_A = 16'h7F47;
  localparam logic [ADDR_W-1:0] ADDR_FUNC_SEL_B = 16'h7FF1;
  localparam logic [DATA_W-1:0] RESET_OUTPUT_LATCH = 8'h00;
  localparam logic [DATA_W-1:0] RESET_DIRECTION = 8'h00;
  localparam logic [DATA_W-1:0] RESET_FUNC_SEL_A = 8'h00;
  localparam logic [DATA_W-1:0] RESET_FUNC_SEL_B = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
  // Pin one carries the serial data input
  localparam int SERIAL_IN_PIN = 1;
endpackage

// ==== design/pin_function_cell.sv ====
`timescale 1ns/1ps
module pin_function_cell
  import port1_pkg::*;
(
  input wire logic sel_a_i,
  input wire logic sel_b_i,
  input wire logic latch_i,
  input wire logic dir_i,
  input wire logic serial_data_i,
  output logic drive_o,
  output logic drive_en_o,
  output logic pull_up_o,
  output logic slow_slew_o,
  output logic invert_read_o
);
  always_comb
  begin
    drive_o = 1'b0;
    drive_en_o = 1'b0;
    pull_up_o = 1'b0;
    slow_slew_o = 1'b0;
    invert_read_o = 1'b0;
    unique case ({sel_a_i, sel_b_i, latch_i, dir_i})
      4'h0: ;
      4'h2: pull_up_o = 1'b1;
      4'h1: drive_en_o = 1'b1;
      4'h3:
      begin
        drive_o = 1'b1;
        drive_en_o = 1'b1;
      end
      4'h4:
      begin
        drive_en_o = 1'b1;
        slow_slew_o = 1'b1;
      end
      4'h6:
      begin
        drive_o = 1'b1;
        drive_en_o = 1'b1;
        slow_slew_o = 1'b1;
      end
      4'h5: drive_en_o = 1'b1;
      4'h7: invert_read_o = 1'b1;
      4'h8: drive_en_o = 1'b1;
      4'hA:
      begin
        drive_o = ~serial_data_i;
        drive_en_o = 1'b1;
        invert_read_o = 1'b1;
      end
      4'h9:
      begin
        drive_o = serial_data_i;
        drive_en_o = 1'b1;
      end
      4'hB:
      begin
        drive_o = 1'b1;
        drive_en_o = 1'b1;
      end
      4'hC:
      begin
        drive_en_o = 1'b1;
        slow_slew_o = 1'b1;
      end
      4'hE:
      begin
        drive_o = serial_data_i;
        drive_en_o = 1'b1;
        slow_slew_o = 1'b1;
      end
      // Open drain: pull low only, release for a one
      4'hD: drive_en_o = ~serial_data_i;
      4'hF: ;
    endcase
  end
endmodule

// ==== tb/port1_properties.sv ====
`timescale 1ns/1ps
module port1_properties
  import port1_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [NUM_PINS-1:0] pin_oe_o,
  input wire logic [NUM_PINS-1:0] pull_up_o,
  input wire logic [NUM_PINS-1:0] slow_slew_o,
  input wire logic serial_data_in_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire rin = rd_i && addr_i == ADDR_PIN_INPUT;
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata not idle");
  unmapped_read_a: assert property (rd_i && addr_i == 16'h7F48 |=>
    rdata_o == 8'h00) else $error("unmapped read");
  in_upper_a: assert property (rin |=> rdata_o[7:2] == 6'h00)
    else $error("input upper bits");
  in_serial_a: assert property (rin |=>
    rdata_o[1] == $past(serial_data_in_o)) else $error("serial in");
  in_readonly_a: assert property (wr_i && addr_i == ADDR_PIN_INPUT |=>
    $stable(pull_up_o) && $stable(slow_slew_o)) else $error("input wr");
  pull_open_a: assert property ((pull_up_o & pin_oe_o) == 2'h0)
    else $error("pull with drive");
  slow_drive_a: assert property ((slow_slew_o & ~pin_oe_o) == 2'h0)
    else $error("slow not driving");
  reset_open_a: assert property (disable iff (1'b0) reset_i |=>
    pin_oe_o == 2'h0 && pull_up_o == 2'h0) else $error("reset open");
  cover property (rin);
  cover property (wr_i && addr_i == ADDR_DIRECTION);
  cover property (pin_oe_o != 2'h0);
  cover property (pull_up_o != 2'h0);
endmodule
bind port1_pin_function_control port1_properties port1_properties_inst (
  .sys_clk_i, .reset_i, .addr_i, .wr_i, .rd_i, .rdata_o, .pin_oe_o,
  .pull_up_o, .slow_slew_o, .serial_data_in_o);

// ==== tb/ext_circuit.sv ====
`timescale 1ns/1ps
module ext_circuit
  import port1_pkg::*;
(
  input wire logic [NUM_PINS-1:0] drv_i,
  input wire logic [NUM_PINS-1:0] oe_i,
  input wire logic [NUM_PINS-1:0] pu_i,
  input wire logic [NUM_PINS-1:0] ext_i,
  input wire logic ext_en_i,
  output logic [NUM_PINS-1:0] lvl_o
);
  // Device drive wins, else the outside driver, else the pull-up
  assign lvl_o = oe_i & drv_i | ~oe_i & (ext_en_i ? ext_i : pu_i);
endmodule

// ==== tb/port1_pin_function_control_tb.sv ====
`timescale 1ns/1ps
module port1_pin_function_control_tb;
  import port1_pkg::*;
  logic sys_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0;
  logic serial_data_out_i = 0, serial_data_in_o;
  logic [ADDR_W-1:0] addr_i = 0;
  logic [DATA_W-1:0] wdata_i = 0, rdata_o;
  logic [1:0] pin_i, pin_o, pin_oe_o, pull_up_o, slow_slew_o, v, x;
  logic [3:0] q;
  logic [1:0] ext_lvl = 2'h1;
  logic ext_en = 1'b1;
  // Per state {inv, nibble with serial 1, nibble with serial 0}
  logic [11:0] t [16] = '{12'h000, 12'h088, 12'h022, 12'h0CC, 12'h099,
    12'h088, 12'h0DD, 12'h100, 12'h088, 12'h0C8, 12'h18C, 12'h0CC,
    12'h099, 12'h008, 12'h0D9, 12'h000};
  int n_errors = 0, samples_checked = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  port1_pin_function_control port1_pin_function_control_inst (.sys_clk_i,
    .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i, .pin_o,
    .pin_oe_o, .pull_up_o, .slow_slew_o, .serial_data_out_i,
    .serial_data_in_o);
  ext_circuit ext_circuit_inst (.drv_i(pin_o), .oe_i(pin_oe_o),
    .pu_i(pull_up_o), .ext_i(ext_lvl), .ext_en_i(ext_en), .lvl_o(pin_i));
  task chk(string n, logic [7:0] ex, logic [7:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      n_errors++;
      $display("wrong value %s exp %h got %h", n, ex, got);
    end
  endtask
  task wr(logic [15:0] a, logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 0;
  endtask
  task rd(logic [15:0] a, logic [7:0] ex);
    @(posedge sys_clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 0;
    #1 chk("rdata", ex, rdata_o);
  endtask
  task end_sim;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge sys_clk_i);
    n_errors++;
    end_sim;
  end
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 0;
    rd(ADDR_OUTPUT_LATCH, 8'h00);
    rd(ADDR_DIRECTION, 8'h00);
    rd(ADDR_FUNC_SEL_A, 8'h00);
    rd(ADDR_FUNC_SEL_B, 8'h00);
    rd(16'h7F48, 8'h00);
    wr(ADDR_FUNC_SEL_B, 8'hA5);
    wr(ADDR_PIN_INPUT, 8'hFF);
    rd(ADDR_FUNC_SEL_B, 8'hA5);
    wr(ADDR_OUTPUT_LATCH, 8'h5A);
    wr(ADDR_DIRECTION, 8'h3C);
    wr(ADDR_FUNC_SEL_A, 8'hC3);
    rd(ADDR_OUTPUT_LATCH, 8'h5A);
    rd(ADDR_DIRECTION, 8'h3C);
    rd(ADDR_FUNC_SEL_A, 8'hC3);
    $display("test registers done");
    @(posedge sys_clk_i);
    reset_i <= 1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 0;
    rd(ADDR_OUTPUT_LATCH, 8'h00);
    rd(ADDR_DIRECTION, 8'h00);
    rd(ADDR_FUNC_SEL_A, 8'h00);
    rd(ADDR_FUNC_SEL_B, 8'h00);
    chk("pins", 8'h00, {pin_oe_o, pin_o, pull_up_o, slow_slew_o});
    $display("test reset done");
    for (int c = 0; c < 64; c++)
    begin
      wr(ADDR_FUNC_SEL_A, {8{c[3]}});
      wr(ADDR_FUNC_SEL_B, {8{c[2]}});
      wr(ADDR_OUTPUT_LATCH, {8{c[1]}});
      wr(ADDR_DIRECTION, {8{c[0]}});
      serial_data_out_i <= c[4];
      ext_lvl <= c[5] ? 2'h2 : 2'h1;
      repeat (3) @(posedge sys_clk_i);
      q = c[4] ? t[c[3:0]][7:4] : t[c[3:0]][3:0];
      v = q[3] ? {2{q[2]}} : ext_lvl;
      x = v ^ {2{t[c[3:0]][8]}};
      chk("pins", {{2{q[3]}}, {2{q[2]}}, {2{q[1]}}, {2{q[0]}}},
        {pin_oe_o, pin_o & pin_oe_o, pull_up_o, slow_slew_o});
      rd(ADDR_PIN_INPUT, {6'h00, x});
      chk("serial in", {7'h00, x[1]}, {7'h00, serial_data_in_o});
    end
    $display("test pin states done");
    ext_en <= 1'b0;
    wr(ADDR_FUNC_SEL_A, 8'h00);
    wr(ADDR_FUNC_SEL_B, 8'h00);
    wr(ADDR_DIRECTION, 8'h00);
    wr(ADDR_OUTPUT_LATCH, 8'hFF);
    repeat (3) @(posedge sys_clk_i);
    chk("pins", 8'h0C, {pin_oe_o, pin_o, pull_up_o, slow_slew_o});
    rd(ADDR_PIN_INPUT, 8'h03);
    wr(ADDR_OUTPUT_LATCH, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    chk("pins", 8'h00, {pin_oe_o, pin_o, pull_up_o, slow_slew_o});
    rd(ADDR_PIN_INPUT, 8'h00);
    $display("test pull-up done");
    end_sim;
  end
endmodule
